// ==== logic/rbc_top.sv ====
// reset sequencing, strap capture, pll setting and test access for the core
`timescale 1ns/1ps
module rbc_top #(
    parameter int unsigned LOCK_CYCLES = rbc_pkg::LOCK_CYCLES,
    parameter int unsigned SCAN_LEN    = rbc_pkg::SCAN_LEN
) (
    input  wire logic       clk,            // input_clock, 40 MHz
    input  wire logic       rst_n,          // processor reset, sync, active low
    input  wire logic [1:0] boot_cfg,       // boot mode straps
    input  wire logic [1:0] clk_cfg,        // clock ratio straps
    input  wire logic       pm_wr,          // power_mgmt_control_reg write strobe
    input  wire logic [5:0] pm_mult,        // written pll multiplier
    input  wire logic [1:0] pm_div,         // written pll divider
    input  wire logic       tck,            // test clock pin
    input  wire logic       trst_n,         // test reset pin, active low
    input  wire logic       tms,            // test mode select pin
    input  wire logic       tdi,            // test data in pin
    output logic            tdo,            // test data out
    output logic            tdo_oe,         // high while tdo driven
    output logic            core_run,       // core may fetch from reset vector
    output logic            pll_locking,    // lock wait in progress
    output logic [1:0]      boot_mode,      // captured boot mode
    output logic [5:0]      pll_mult,       // current pll multiplier
    output logic [1:0]      pll_div,        // current pll divider
    output logic            pm_accepted,    // pulse: pll setting taken
    output logic [3:0]      tap_state       // test state machine state
);
    localparam int unsigned CW = $clog2(LOCK_CYCLES + 1);

    // refuse a lock wait the counter cannot serve
    if (LOCK_CYCLES < 1) begin : g_lock_chk
        $error("lock wait must be at least one cycle");
    end

    typedef enum logic [2:0] {
        S_RESET = 3'b001,
        S_LOCK  = 3'b010,
        S_RUN   = 3'b100
    } rbc_seq_t;

    rbc_seq_t       st_ff, nxt_st;
    logic [CW-1:0]  cnt_ff, nxt_cnt;
    logic [1:0]     boot_ff, nxt_boot;
    logic [5:0]     mult_ff, nxt_mult;
    logic [1:0]     div_ff, nxt_div;
    logic           acc_ff, nxt_acc;
    logic [2:0]     tck_s_ff, trst_s_ff, tms_s_ff, tdi_s_ff;
    logic           tck_q_ff, trst_q_ff, tms_q_ff, tdi_q_ff;
    logic           tck_rise, tck_fall;

    // pin synchronisers; a level is taken once stages two and three agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tck_s_ff  <= 3'h0;
            trst_s_ff <= 3'h0;
            tms_s_ff  <= 3'h7;
            tdi_s_ff  <= 3'h7;
            tck_q_ff  <= 1'b0;
            trst_q_ff <= 1'b0;
            tms_q_ff  <= 1'b1;
            tdi_q_ff  <= 1'b1;
        end else begin
            tck_s_ff  <= {tck_s_ff[1:0], tck};
            trst_s_ff <= {trst_s_ff[1:0], trst_n};
            tms_s_ff  <= {tms_s_ff[1:0], tms};
            tdi_s_ff  <= {tdi_s_ff[1:0], tdi};
            if (tck_s_ff[1] == tck_s_ff[2])   tck_q_ff  <= tck_s_ff[2];
            if (trst_s_ff[1] == trst_s_ff[2]) trst_q_ff <= trst_s_ff[2];
            if (tms_s_ff[1] == tms_s_ff[2])   tms_q_ff  <= tms_s_ff[2];
            if (tdi_s_ff[1] == tdi_s_ff[2])   tdi_q_ff  <= tdi_s_ff[2];
        end
    end

    // test clock edges from the filtered level; the board must idle tck low after power-up
    assign tck_rise = (tck_s_ff[1] == tck_s_ff[2]) && tck_s_ff[2] && !tck_q_ff;
    assign tck_fall = (tck_s_ff[1] == tck_s_ff[2]) && !tck_s_ff[2] && tck_q_ff;

    // lock wait: counter starts from zero after each reset, core held until it ends
    always_comb begin
        nxt_st  = st_ff;
        nxt_cnt = cnt_ff;
        case (st_ff)
            S_RESET: begin
                nxt_cnt = '0;
                nxt_st  = S_LOCK;
            end
            S_LOCK: begin
                nxt_cnt = cnt_ff + CW'(1);
                if (cnt_ff == CW'(LOCK_CYCLES - 1)) nxt_st = S_RUN;
            end
            S_RUN:   nxt_st = S_RUN;
            default: nxt_st = S_RESET;
        endcase
    end

    // straps set start-up ratio and boot mode; software may retune once running
    always_comb begin
        nxt_boot = boot_ff;
        nxt_mult = mult_ff;
        nxt_div  = div_ff;
        nxt_acc  = 1'b0;
        if (st_ff == S_RESET) begin
            // straps are stable across reset release, so sampling in the first cycle after release is safe
            nxt_boot = boot_cfg;
            nxt_div  = rbc_pkg::DIV_RST;
            case (clk_cfg)
                rbc_pkg::CLKCFG_6:  nxt_mult = rbc_pkg::MULT_6;
                rbc_pkg::CLKCFG_32: nxt_mult = rbc_pkg::MULT_32;
                rbc_pkg::CLKCFG_16: nxt_mult = rbc_pkg::MULT_16;
                default:            nxt_mult = rbc_pkg::MULT_6;
            endcase
        end else if (st_ff == S_RUN && pm_wr) begin
            nxt_mult = pm_mult;
            nxt_div  = pm_div;
            nxt_acc  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff   <= S_RESET;
            cnt_ff  <= '0;
            boot_ff <= rbc_pkg::BOOT_SPI_SLAVE;
            mult_ff <= rbc_pkg::MULT_RST;
            div_ff  <= rbc_pkg::DIV_RST;
            acc_ff  <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            boot_ff <= nxt_boot;
            mult_ff <= nxt_mult;
            div_ff  <= nxt_div;
            acc_ff  <= nxt_acc;
        end
    end

    // test reset pin forced low is held in tap reset; board pulses it after power-up
    rbc_tap #(
        .LEN        (SCAN_LEN)
    ) u_tap (
        .clk        (clk),
        .rst_n      (rst_n),
        .trst_n     (trst_q_ff),
        .tck_rise   (tck_rise),
        .tck_fall   (tck_fall),
        .tms        (tms_q_ff),
        .tdi        (tdi_q_ff),
        .tdo        (tdo),
        .tdo_oe     (tdo_oe),
        .tap_state  (tap_state)
    );

    assign core_run    = (st_ff == S_RUN);
    assign pll_locking = (st_ff == S_LOCK);
    assign boot_mode   = boot_ff;
    assign pll_mult    = mult_ff;
    assign pll_div     = div_ff;
    assign pm_accepted = acc_ff;
endmodule

// ==== logic/rbc_pkg.sv ====
// shared constants for the reset, boot and clock configuration block
package rbc_pkg;
    localparam int unsigned LOCK_CYCLES     = 4096;   // input_clock cycles for pll lock
    localparam int unsigned CLK_HZ          = 40000000;
    localparam logic [1:0]  BOOT_SPI_SLAVE  = 2'h0;
    localparam logic [1:0]  BOOT_SPI_MASTER = 2'h1;
    localparam logic [1:0]  BOOT_AMI_EPROM  = 2'h2;
    localparam logic [1:0]  CLKCFG_6        = 2'h0;
    localparam logic [1:0]  CLKCFG_32       = 2'h1;
    localparam logic [1:0]  CLKCFG_16       = 2'h2;
    localparam logic [5:0]  MULT_6          = 6'h06;
    localparam logic [5:0]  MULT_32         = 6'h20;
    localparam logic [5:0]  MULT_16         = 6'h10;
    localparam logic [5:0]  MULT_RST        = 6'h06;
    localparam logic [1:0]  DIV_RST         = 2'h0;
    localparam int unsigned SCAN_LEN        = 8;      // boundary-scan chain length
    localparam logic [3:0]  IR_BYPASS       = 4'hF;
endpackage

// ==== logic/rbc_tap.sv ====
// boundary-scan tap controller with a bypass bit and a scan chain
`timescale 1ns/1ps
module rbc_tap #(
    parameter int unsigned LEN = rbc_pkg::SCAN_LEN
) (
    input  wire logic           clk,        // system clock
    input  wire logic           rst_n,      // sync reset, active low
    input  wire logic           trst_n,     // synchronised test reset, active low
    input  wire logic           tck_rise,   // one-cycle pulse on test clock rise
    input  wire logic           tck_fall,   // one-cycle pulse on test clock fall
    input  wire logic           tms,        // synchronised test mode select
    input  wire logic           tdi,        // synchronised test data in
    output logic                tdo,        // test data out
    output logic                tdo_oe,     // high while shifting
    output logic [3:0]          tap_state   // current tap state
);
    // the shift slice below needs at least two chain bits
    if (LEN < 2) begin : g_len_chk
        $error("scan length must be at least two");
    end

    typedef enum logic [3:0] {
        RESET = 4'h0, IDLE = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3, SH_DR = 4'h4, EX1_DR = 4'h5,
        PA_DR = 4'h6, EX2_DR = 4'h7, UP_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SH_IR = 4'hB,
        EX1_IR = 4'hC, PA_IR = 4'hD, EX2_IR = 4'hE, UP_IR = 4'hF
    } rbc_tap_t;

    rbc_tap_t           st_ff, nxt_st;
    logic [LEN-1:0]     chain_ff, nxt_chain;
    logic [3:0]         ir_ff, nxt_ir, irs_ff, nxt_irs;
    logic               byp_ff, nxt_byp, tdo_ff, nxt_tdo;

    // state walk on tms at each test clock rise; trst forces reset
    always_comb begin
        nxt_st = st_ff;
        if (!trst_n) begin
            nxt_st = RESET;
        end else if (tck_rise) begin
            case (st_ff)
                RESET:   nxt_st = tms ? RESET  : IDLE;
                IDLE:    nxt_st = tms ? SEL_DR : IDLE;
                SEL_DR:  nxt_st = tms ? SEL_IR : CAP_DR;
                CAP_DR:  nxt_st = tms ? EX1_DR : SH_DR;
                SH_DR:   nxt_st = tms ? EX1_DR : SH_DR;
                EX1_DR:  nxt_st = tms ? UP_DR  : PA_DR;
                PA_DR:   nxt_st = tms ? EX2_DR : PA_DR;
                EX2_DR:  nxt_st = tms ? UP_DR  : SH_DR;
                UP_DR:   nxt_st = tms ? SEL_DR : IDLE;
                SEL_IR:  nxt_st = tms ? RESET  : CAP_IR;
                CAP_IR:  nxt_st = tms ? EX1_IR : SH_IR;
                SH_IR:   nxt_st = tms ? EX1_IR : SH_IR;
                EX1_IR:  nxt_st = tms ? UP_IR  : PA_IR;
                PA_IR:   nxt_st = tms ? EX2_IR : PA_IR;
                EX2_IR:  nxt_st = tms ? UP_IR  : SH_IR;
                UP_IR:   nxt_st = tms ? SEL_DR : IDLE;
                default: nxt_st = RESET;
            endcase
        end
    end

    // data and instruction shifting; bypass unless ir selects the chain
    always_comb begin
        nxt_chain = chain_ff;
        nxt_ir    = ir_ff;
        nxt_irs   = irs_ff;
        nxt_byp   = byp_ff;
        nxt_tdo   = tdo_ff;
        if (!trst_n || st_ff == RESET) begin
            nxt_ir = rbc_pkg::IR_BYPASS;
        end else if (tck_rise) begin
            case (st_ff)
                CAP_DR:  nxt_byp = 1'b0;
                SH_DR: begin
                    nxt_chain = {tdi, chain_ff[LEN-1:1]};
                    nxt_byp   = tdi;
                end
                CAP_IR:  nxt_irs = 4'h1;
                SH_IR:   nxt_irs = {tdi, irs_ff[3:1]};
                UP_IR:   nxt_ir  = irs_ff;
                default: nxt_byp = byp_ff;
            endcase
        end
        // tdo changes on the falling test clock edge
        if (tck_fall) begin
            if (st_ff == SH_IR) nxt_tdo = irs_ff[0];
            else if (ir_ff == rbc_pkg::IR_BYPASS) nxt_tdo = byp_ff;
            else nxt_tdo = chain_ff[0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_ff    <= RESET;
            chain_ff <= '0;
            ir_ff    <= rbc_pkg::IR_BYPASS;
            irs_ff   <= 4'h0;
            byp_ff   <= 1'b0;
            tdo_ff   <= 1'b0;
        end else begin
            st_ff    <= nxt_st;
            chain_ff <= nxt_chain;
            ir_ff    <= nxt_ir;
            irs_ff   <= nxt_irs;
            byp_ff   <= nxt_byp;
            tdo_ff   <= nxt_tdo;
        end
    end

    assign tdo       = tdo_ff;
    assign tdo_oe    = (st_ff == SH_DR) || (st_ff == SH_IR);
    assign tap_state = st_ff;
endmodule

// ==== testbench/rbc_chk.sv ====
// concurrent checks on the ports of the reset, boot and clock configuration block
`timescale 1ns/1ps
module rbc_chk #(
    parameter int unsigned LOCK_CYCLES = rbc_pkg::LOCK_CYCLES
) (
    input wire logic       clk,         // input clock
    input wire logic       rst_n,       // processor reset, active low
    input wire logic [1:0] boot_cfg,    // boot straps
    input wire logic [1:0] clk_cfg,     // clock straps
    input wire logic       pm_wr,       // pll setting write strobe
    input wire logic [5:0] pm_mult,     // written multiplier
    input wire logic [1:0] pm_div,      // written divider
    input wire logic       trst_n,      // test reset, active low
    input wire logic       tdo_oe,      // tdo driven
    input wire logic       core_run,    // fetch allowed
    input wire logic       pll_locking, // lock wait running
    input wire logic [1:0] boot_mode,   // captured boot mode
    input wire logic [5:0] pll_mult,    // current multiplier
    input wire logic [1:0] pll_div,     // current divider
    input wire logic       pm_accepted, // write taken pulse
    input wire logic [3:0] tap_state    // tap state
);
    int unsigned cnt_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cycles since release; saturates so a long run cannot wrap into the window
    always_ff @(posedge clk) begin
        if (!rst_n) cnt_ff <= 0;
        else if (cnt_ff <= LOCK_CYCLES) cnt_ff <= cnt_ff + 1;
    end
    // start-up multiplier chosen by the clock straps
    function automatic logic [5:0] mmap(input logic [1:0] c);
        case (c)
            rbc_pkg::CLKCFG_32: return rbc_pkg::MULT_32;
            rbc_pkg::CLKCFG_16: return rbc_pkg::MULT_16;
            default: return rbc_pkg::MULT_6;
        endcase
    endfunction
    a_reset_state: assert property (disable iff (1'b0)
        !rst_n |=> !core_run && !pll_locking && !pm_accepted && !tdo_oe
        && boot_mode == rbc_pkg::BOOT_SPI_SLAVE && tap_state == 4'h0
        && pll_mult == rbc_pkg::MULT_RST && pll_div == rbc_pkg::DIV_RST)
        else $error("reset state");
    a_core_gate: assert property (core_run == (cnt_ff > LOCK_CYCLES))
        else $error("core run timing");
    a_lock_window: assert property (
        pll_locking == (cnt_ff != 0 && cnt_ff <= LOCK_CYCLES)) else $error("lock window");
    a_strap_take: assert property ($rose(rst_n) |=>
        boot_mode == $past(boot_cfg) && pll_mult == mmap($past(clk_cfg))
        && pll_div == rbc_pkg::DIV_RST) else $error("straps");
    a_setting_hold: assert property (
        !$rose(rst_n) && !(pm_wr && core_run) |=>
        $stable(boot_mode) && $stable(pll_mult) && $stable(pll_div)) else $error("setting moved");
    a_pm_take: assert property (pm_wr && core_run |=> pm_accepted
        && pll_mult == $past(pm_mult) && pll_div == $past(pm_div)) else $error("write lost");
    a_pm_refuse: assert property (pm_wr && !core_run |=> !pm_accepted)
        else $error("write taken early");
    a_pm_pulse: assert property (pm_accepted |-> $past(pm_wr) && $past(core_run))
        else $error("stray accept");
    a_trst_force: assert property (!trst_n [*6] |-> tap_state == 4'h0)
        else $error("test reset ignored");
    a_tdo_drive: assert property (tdo_oe == (tap_state == 4'h4 || tap_state == 4'hB))
        else $error("tdo enable");
endmodule
bind rbc_top rbc_chk #(.LOCK_CYCLES(LOCK_CYCLES)) rbc_chk_inst (.clk(clk), .rst_n(rst_n),
    .boot_cfg(boot_cfg), .clk_cfg(clk_cfg), .pm_wr(pm_wr), .pm_mult(pm_mult), .pm_div(pm_div),
    .trst_n(trst_n), .tdo_oe(tdo_oe), .core_run(core_run), .pll_locking(pll_locking),
    .boot_mode(boot_mode), .pll_mult(pll_mult), .pll_div(pll_div), .pm_accepted(pm_accepted),
    .tap_state(tap_state));

// ==== testbench/rbc_board.sv ====
// board side model: reset source, strap resistors and scan controller
`timescale 1ns/1ps
module rbc_board (
    input  wire logic  clk,      // input clock
    input  wire logic  tdo,      // scan data from the device
    output logic       rst_n,    // processor reset, active low
    output logic [1:0] boot_cfg, // boot straps
    output logic [1:0] clk_cfg,  // clock straps
    output logic       tck,      // test clock, held low between bits
    output logic       trst_n,   // test reset, active low
    output logic       tms,      // mode select, idles high like its pull-up
    output logic       tdi       // scan data, idles high like its pull-up
);
    // power-up levels: both resets low, test clock held low
    initial begin
        rst_n = 1'b0;
        trst_n = 1'b0;
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        boot_cfg = 2'h0;
        clk_cfg = 2'h0;
    end
    // straps settle a cycle before reset falls, then stay until the next reset
    task automatic reset_pulse(input logic [1:0] b, input logic [1:0] c);
        @(posedge clk);
        boot_cfg <= b;
        clk_cfg <= c;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    // test reset pulse long enough to pass the pin filter
    task automatic trst_pulse();
        @(posedge clk);
        trst_n <= 1'b0;
        repeat (8) @(posedge clk);
        trst_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    // one test clock of 19 input clocks; tms and tdi lead the rise so the filter sees them set
    task automatic tck_bit(input logic m, input logic d, output logic q);
        @(posedge clk);
        q = tdo;
        tms <= m;
        tdi <= d;
        repeat (2) @(posedge clk);
        tck <= 1'b1;
        repeat (8) @(posedge clk);
        tck <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ==== testbench/testbench.sv ====
// self-checking bench for the reset, boot and clock configuration block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    localparam int unsigned LOCK = 8; // shortened lock wait keeps the run brief
    logic        clk = 1'b0;
    logic        pm_wr = 1'b0;
    logic [5:0]  pm_mult = 6'h00;
    logic [1:0]  pm_div = 2'h0;
    logic        rst_n, tck, trst_n, tms, tdi, tdo, tdo_oe, core_run, pll_locking, pm_accepted;
    logic [1:0]  boot_cfg, clk_cfg, boot_mode, pll_div, b, c, d;
    logic [5:0]  pll_mult, m;
    logic [3:0]  tap_state;
    logic [31:0] outs, dat;
    int          err_total = 0, check_count = 0, n;
    // free-running input clock
    always #12.5 clk = ~clk;
    rbc_board rbc_board_inst (.clk(clk), .tdo(tdo), .rst_n(rst_n), .boot_cfg(boot_cfg),
        .clk_cfg(clk_cfg), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi));
    rbc_top #(.LOCK_CYCLES(LOCK)) rbc_top_inst (.clk(clk), .rst_n(rst_n), .boot_cfg(boot_cfg),
        .clk_cfg(clk_cfg), .pm_wr(pm_wr), .pm_mult(pm_mult), .pm_div(pm_div), .tck(tck),
        .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .core_run(core_run),
        .pll_locking(pll_locking), .boot_mode(boot_mode), .pll_mult(pll_mult),
        .pll_div(pll_div), .pm_accepted(pm_accepted), .tap_state(tap_state));
    // start-up multiplier expected from the clock straps
    function automatic logic [5:0] exp_mult(input logic [1:0] s);
        case (s)
            rbc_pkg::CLKCFG_32: return rbc_pkg::MULT_32;
            rbc_pkg::CLKCFG_16: return rbc_pkg::MULT_16;
            default: return rbc_pkg::MULT_6;
        endcase
    endfunction
    task automatic finish_test();
        if (err_total == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // walk the tap with tms and tdi given lsb first, keeping tdo seen before each rise
    task automatic jseq(input logic [31:0] mv, input logic [31:0] dv, input int len);
        logic q;
        for (int k = 0; k < len; k++) begin
            rbc_board_inst.tck_bit(mv[k], dv[k], q);
            outs[k] = q;
        end
    endtask
    // main sequence
    initial begin
        void'($urandom(90));
        // leave power-up reset with straps unchanged, so later strap moves precede each reset
        rbc_board_inst.reset_pulse(2'h0, 2'h0);
        for (int i = 0; i < 5; i++) begin
            b = 2'($urandom_range(2));
            c = 2'(i);
            if (i == 1) begin
                rbc_board_inst.reset_pulse(b, c); // lock cut short by a second reset
                repeat (4) @(posedge clk);
            end
            rbc_board_inst.reset_pulse(b, c);
            pm_wr <= 1'b1; // arrives in the strap-capture cycle before locking, so it must not stick
            pm_mult <= 6'h3F;
            n = 0;
            while (core_run !== 1'b1) begin
                @(posedge clk);
                pm_wr <= 1'b0;
                #1;
                n++;
                if (n > 40) begin
                    err_total++;
                    finish_test();
                end
            end
            `CHK(n, LOCK + 1)
            `CHK(pll_locking, 1'b0)
            `CHK(boot_mode, b)
            `CHK({pll_mult, pll_div}, {exp_mult(c), rbc_pkg::DIV_RST})
            for (int j = 0; j < 3; j++) begin
                m = 6'($urandom);
                d = 2'($urandom);
                @(posedge clk);
                pm_wr <= 1'b1;
                pm_mult <= m;
                pm_div <= d;
                @(posedge clk);
                #1;
                `CHK({pll_mult, pll_div, pm_accepted}, {m, d, 1'b1})
            end
            @(posedge clk);
            pm_wr <= 1'b0;
        end
        rbc_board_inst.trst_pulse();
        `CHK(tap_state, 4'h0)
        jseq(32'h0000_0B06, 32'h0, 14);
        `CHK(outs[8:5], 4'h1)
        `CHK(tap_state, 4'h4)
        `CHK(tdo_oe, 1'b1)
        dat = $urandom;
        jseq(32'h0000_8000, dat, 16);
        `CHK(outs[15:8], dat[7:0])
        jseq(32'h0000_001F, 32'hFFFF_FFFF, 5);
        `CHK(tap_state, 4'h0)
        // tap reset restores bypass: one-bit path that captures zero, then echoes tdi a bit late
        dat = $urandom;
        jseq(32'h0000_3F02, dat, 14);
        `CHK(outs[9:4], {dat[8:4], 1'b0})
        finish_test();
    end
endmodule
